// ===== logic/banked_eeprom_controller.v
`timescale 1ns/1ps
`include "nvm_bank_defines.vh"
// ==========================================================
// Paged RAM/EEPROM window with byte and row programming
module banked_eeprom_controller #(
  parameter NVM_PAGES = 2,
  parameter PROG_CYCLES = `PROG_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Data-space access from the core
  input wire [7:0] addr,
  input wire rdEn,
  input wire wrEn,
  input wire [7:0] wrData,
  output reg [7:0] rdData,
  output reg rdValid,
  output reg accessError,
  // Power control
  input wire stopExec,
  input wire wakeUp,
  // Status
  output reg nvmPowered,
  output reg progBusy
);
  // ========================================================
  // State
  localparam ST_IDLE = 2'd0;
  localparam ST_BYTE = 2'd1;
  localparam ST_ROW = 2'd2;

  reg [7:0] pageBankSelect;
  reg nvmProgEnable;
  reg nvmStandby;
  reg rowModeEnable;
  reg rowWriteStart;
  reg stopped;
  reg [1:0] state;
  reg [31:0] busyCount;
  reg [7:0] rowLatch [0:7];
  reg [7:0] rowDirty;
  reg [4:0] rowAddr;
  reg rowValid;
  reg [7:0] byteAddr;
  reg [7:0] byteData;
  reg [2:0] flushIdx;
  reg rdFromMem;
  reg rdFromCtrl;
  reg [7:0] ctrlReadback;
  reg [1:0] selPage;
  integer i;

  // Memory map: page 0 RAM2, pages 1.. EEPROM, 64 bytes each.
  function [1:0] page_of;
    input [7:0] sel;
    begin
      case (sel)
        `BANK_RAM2: page_of = 2'd0;
        `BANK_NVM0: page_of = 2'd1;
        `BANK_NVM1: page_of = (NVM_PAGES > 1) ? 2'd2 : 2'd3;
        default: page_of = 2'd3;
      endcase
    end
  endfunction

  wire inWindow = (addr <= `WIN_LAST); // RULE4
  wire [1:0] curPage = page_of(pageBankSelect);
  wire isRam = inWindow && (curPage == 2'd0); // RULE2
  wire isNvm = inWindow && (curPage == 2'd1 || curPage == 2'd2); // RULE3
  wire busy = (state != ST_IDLE);
  // RULE8 RULE22
  wire nvmOn = !nvmStandby && !stopped && isNvm;
  // RULE9
  wire nvmOk = nvmOn && !busy;
  wire ctrlWr = wrEn && (addr == `ADDR_NVM_CTRL) && !busy; // RULE10
  wire sameRow = !rowValid || (rowAddr == {selPage, addr[5:3]}); // RULE15

  // ========================================================
  // Memory port muxing
  reg memWr;
  reg [7:0] memWrAddr;
  reg [7:0] memWrData;
  wire [7:0] memRd;
  always @* begin
    memWr = 1'b0;
    memWrAddr = {curPage, addr[5:0]};
    memWrData = wrData;
    if (wrEn && isRam) begin
      memWr = 1'b1;
    end else if (state == ST_BYTE && busyCount == 32'd1) begin
      memWr = 1'b1; // RULE13
      memWrAddr = byteAddr;
      memWrData = byteData;
    end else if (state == ST_ROW && busyCount <= 32'd8 &&
                 busyCount != 32'd0 && rowDirty[flushIdx]) begin
      memWr = 1'b1; // RULE17
      memWrAddr = {rowAddr, flushIdx};
      memWrData = rowLatch[flushIdx];
    end
  end

  nvm_bank_mem #(.AW(8), .DEPTH(192)) u_mem (
    .clk(clk),
    .wrEn(memWr),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr({curPage, addr[5:0]}),
    .rdData(memRd)
  );

  // ========================================================
  // Bank select: no reset so contents survive like a RAM cell.
  always @(posedge clk) begin
    if (wrEn && addr == `ADDR_BANK_SEL) begin
      pageBankSelect <= wrData; // RULE1 RULE7 RULE6
    end
  end

  // ========================================================
  // Control, programming sequencer and row latches
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nvmProgEnable <= 1'b0;
      nvmStandby <= 1'b0;
      rowModeEnable <= 1'b0;
      rowWriteStart <= 1'b0;
      stopped <= 1'b0;
      state <= ST_IDLE;
      busyCount <= 32'd0;
      rowDirty <= 8'h00;
      rowAddr <= 5'd0;
      rowValid <= 1'b0;
      byteAddr <= 8'h00;
      byteData <= 8'h00;
      flushIdx <= 3'd0;
      selPage <= 2'd0;
      for (i = 0; i < 8; i = i + 1) begin
        rowLatch[i] <= 8'h00;
      end
    end else begin
      if (stopExec) begin
        stopped <= 1'b1; // RULE22
      end else if (wakeUp) begin
        stopped <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (ctrlWr) begin
            nvmProgEnable <= wrData[`BIT_ENABLE];
            nvmStandby <= wrData[`BIT_STANDBY];
            rowModeEnable <= wrData[`BIT_ROW_MODE];
            if (wrData[`BIT_ROW_MODE] && !rowModeEnable) begin
              rowDirty <= 8'h00; // RULE14
              rowValid <= 1'b0;
              for (i = 0; i < 8; i = i + 1) begin
                rowLatch[i] <= 8'h00;
              end
            end
            if (!wrData[`BIT_ROW_MODE]) begin
              rowDirty <= 8'h00; // RULE20
              rowValid <= 1'b0;
            end
            // RULE18
            if (wrData[`BIT_ROW_START] && wrData[`BIT_ENABLE] &&
                wrData[`BIT_ROW_MODE] && rowModeEnable) begin
              rowWriteStart <= 1'b1;
              state <= ST_ROW;
              busyCount <= PROG_CYCLES; // RULE23
              flushIdx <= 3'd0;
            end
          end else if (wrEn && nvmOk && nvmProgEnable) begin // RULE12
            if (rowModeEnable) begin
              if (sameRow) begin // RULE16
                rowLatch[addr[2:0]] <= wrData;
                rowDirty[addr[2:0]] <= 1'b1;
                rowAddr <= {curPage, addr[5:3]};
                selPage <= curPage;
                rowValid <= 1'b1;
              end
            end else begin
              byteAddr <= {curPage, addr[5:0]};
              byteData <= wrData;
              state <= ST_BYTE;
              busyCount <= PROG_CYCLES; // RULE23
            end
          end
          if (!rowValid) begin
            selPage <= curPage;
          end
        end
        ST_BYTE: begin
          busyCount <= busyCount - 32'd1;
          if (busyCount == 32'd1) begin
            state <= ST_IDLE;
          end
        end
        ST_ROW: begin
          busyCount <= busyCount - 32'd1;
          if (busyCount <= 32'd8) begin
            flushIdx <= flushIdx + 3'd1;
          end
          if (busyCount == 32'd1) begin
            state <= ST_IDLE;
            rowModeEnable <= 1'b0; // RULE19
            rowWriteStart <= 1'b0;
            rowDirty <= 8'h00;
            rowValid <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Read path; EEPROM reads match RAM timing.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdFromMem <= 1'b0;
      rdFromCtrl <= 1'b0;
      ctrlReadback <= 8'h00;
      accessError <= 1'b0;
      nvmPowered <= 1'b0;
      progBusy <= 1'b0;
    end else begin
      // RULE11
      rdFromMem <= rdEn && (isRam || (nvmOk && !rowModeEnable));
      rdFromCtrl <= rdEn && (addr == `ADDR_NVM_CTRL);
      ctrlReadback <= {6'h00, busy, 1'b0}; // RULE9
      accessError <= (rdEn || wrEn) && inWindow && !isRam &&
        (!nvmOk || (rowModeEnable && (rdEn || !sameRow))); // RULE16
      nvmPowered <= !nvmStandby && !stopped &&
        (pageBankSelect == `BANK_NVM0 || pageBankSelect == `BANK_NVM1);
      progBusy <= busy;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdFromMem || rdFromCtrl;
      rdData <= rdFromMem ? memRd : (rdFromCtrl ? ctrlReadback : 8'h00);
    end
  end
endmodule // banked_eeprom_controller

// ===== logic/nvm_bank_defines.vh
// Operation
// RULE1: Bank select write-only, full-byte writes at E8h.
// RULE2: Bank value 10h maps second RAM page.
// RULE3: Values 01/02 map EEPROM pages 0/1.
// RULE4: Addresses 00h-3Fh index selected 64-byte bank.
// RULE5: Software sets at most one bank bit.
// RULE6: Bank select untouched by interrupts or calls.
// RULE7: Bank select not reset; software writes first.
// RULE8: Standby or no bank disables EEPROM accesses.
// RULE9: Busy set while programming; accesses aborted.
// RULE10: Control writes ignored while busy.
// RULE11: Idle EEPROM reads like ordinary data reads.
// RULE12: Programming needs enable bit set.
// RULE13: Byte mode programs written byte directly.
// RULE14: Parallel mode clears row latches, latches row.
// RULE15: Row is A7..A3; A2..A0 pick byte.
// RULE16: Other rows and reads forbidden in parallel mode.
// RULE17: Start programs only bytes written since entry.
// RULE18: Start needs enable and parallel mode set.
// RULE19: Cycle end clears parallel and start bits.
// RULE20: Clearing parallel mode abandons row harmlessly.
// RULE21: Software keeps page fixed; bits 5,4 clear.
// RULE22: Stop instruction disables EEPROM immediately.
// RULE23: Busy lasts a configurable cycle count.
`ifndef NVM_BANK_DEFINES_VH
`define NVM_BANK_DEFINES_VH
// ==========================================================
// Register addresses and fields
`define ADDR_BANK_SEL 8'he8
`define ADDR_NVM_CTRL 8'hea
`define BANK_NONE 8'h00
`define BANK_NVM0 8'h01
`define BANK_NVM1 8'h02
`define BANK_RAM2 8'h10
`define WIN_LAST 8'h3f
`define CTRL_RESET 8'h00
`define BIT_ENABLE 0
`define BIT_BUSY 1
`define BIT_ROW_MODE 2
`define BIT_ROW_START 3
`define BIT_STANDBY 6
// Programming time in ns; cycles derived from a 5 ns clock.
`define PROG_TIME_NS 5000
`define CLK_PERIOD_NS 5
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`endif

// ===== logic/nvm_bank_mem.v
`timescale 1ns/1ps
// ==========================================================
// Simple synchronous memory with registered read data
module nvm_bank_mem #(
  parameter AW = 8,
  parameter DEPTH = 192
) (
  // Clock
  input wire clk,
  // Write port
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [7:0] wrData,
  // Read port
  input wire [AW-1:0] rdAddr,
  output reg [7:0] rdData
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // nvm_bank_mem

// ===== verification/banked_eeprom_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks
module banked_eeprom_checker #(
  parameter PROG_CYCLES = 20
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire rdEn,
  input wire wrEn,
  input wire [7:0] rdData,
  input wire rdValid,
  input wire accessError,
  input wire stopExec,
  input wire nvmPowered,
  input wire progBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg [15:0] busyLen;
  sequence ctrlRead;
    rdEn && addr == 8'hea ##2 rdValid;
  endsequence
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      busyLen <= 16'h0000;
    else
      busyLen <= progBusy ? busyLen + 16'h0001 : 16'h0000;
  end
  busy_length_a: assert property (
    $fell(progBusy) |-> busyLen == PROG_CYCLES)
    else $error("programming time wrong");
  valid_cause_a: assert property (
    rdValid |-> $past(rdEn, 2))
    else $error("read answer without request");
  ctrl_answer_a: assert property (
    rdEn && addr == 8'hea |-> ##2 rdValid)
    else $error("control read not answered");
  ctrl_bits_a: assert property (
    ctrlRead |-> rdData[7:2] == 6'h00 && !rdData[0])
    else $error("control read shows more than busy");
  bank_unread_a: assert property (
    rdEn && addr == 8'he8 |-> ##2 !rdValid)
    else $error("bank select was readable");
  busy_abort_a: assert property (
    wrEn && addr <= 8'h3f && progBusy && nvmPowered |=> accessError)
    else $error("access while busy not aborted");
  stop_off_a: assert property (
    stopExec |-> ##2 !nvmPowered)
    else $error("memory stayed powered after stop");
  busy_cause_a: assert property (
    $rose(progBusy) |-> $past(wrEn) || $past(wrEn, 2) || $past(wrEn, 3))
    else $error("programming started without a write");
endmodule // banked_eeprom_checker

bind banked_eeprom_controller banked_eeprom_checker #(
  .PROG_CYCLES(PROG_CYCLES)
) u_chk (
  .clk(clk), .rst_b(rst_b), .addr(addr), .rdEn(rdEn), .wrEn(wrEn),
  .rdData(rdData), .rdValid(rdValid), .accessError(accessError),
  .stopExec(stopExec), .nvmPowered(nvmPowered), .progBusy(progBusy)
);

// ===== verification/banked_eeprom_controller_test.sv
`timescale 1ns/1ps
// ==========================================================
// Access sequences with expected results
module banked_eeprom_controller_test;
  wire [7:0] addr, wrData, rdData;
  wire rdEn, wrEn, rdValid, accessError, nvmPowered, progBusy;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg stopExec = 1'b0;
  reg wakeUp = 1'b0;
  reg [7:0] d;
  reg v, e;
  integer nFail = 0;
  integer totalChecks = 0;
  integer i;
  initial forever #2.5 clk = ~clk;
  banked_eeprom_controller #(.PROG_CYCLES(20)) u_banked_eeprom_controller (
    .clk(clk), .rst_b(rst_b), .addr(addr), .rdEn(rdEn), .wrEn(wrEn),
    .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .accessError(accessError), .stopExec(stopExec), .wakeUp(wakeUp),
    .nvmPowered(nvmPowered), .progBusy(progBusy));
  cpu_core_model u_cpu_core_model (.clk(clk), .addr(addr), .rdEn(rdEn),
    .wrEn(wrEn), .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .accessError(accessError));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [7:0] s, input [7:0] x);
    begin
      totalChecks = totalChecks + 1;
      if (s !== x) begin
        nFail = nFail + 1;
        $display("mismatch at %0t: got %h want %h", $time, s, x);
      end
    end
  endtask
  task w(input [7:0] a, input [7:0] dt);
    u_cpu_core_model.wr(a, dt);
  endtask
  task r(input [7:0] a);
    u_cpu_core_model.rd(a, d, v, e);
  endtask
  // Busy shows with a lag, so let it settle before looking.
  task busy(input b);
    begin
      repeat (3) @(negedge clk);
      chk({7'h00, progBusy}, {7'h00, b});
    end
  endtask
  task idle;
    begin
      for (i = 0; i < 100 && progBusy !== 1'b0; i = i + 1)
        @(negedge clk);
      if (i == 100) begin
        nFail = nFail + 1;
        test_done;
      end
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    w(8'he8, 8'h01);
    r(8'hea); chk(d, 8'h00);
    w(8'hea, 8'h01); w(8'h05, 8'ha5); busy(1'b1);
    r(8'hea); chk(d, 8'h02);
    w(8'hea, 8'h00);
    r(8'h06); chk({7'h00, e}, 8'h01);
    idle; r(8'h05); chk(d, 8'ha5);
    w(8'h1f, 8'h3c); busy(1'b1);
    idle; w(8'hea, 8'h00); w(8'h1f, 8'hc3); busy(1'b0);
    w(8'hea, 8'h09); busy(1'b0);
    $display("test byte done");
    w(8'hea, 8'h05); w(8'h18, 8'h11); w(8'h1a, 8'h22);
    w(8'hea, 8'h0d); busy(1'b1); idle;
    r(8'h18); chk(d, 8'h11);
    r(8'h1a); chk(d, 8'h22);
    r(8'h1f); chk(d, 8'h3c);
    w(8'h18, 8'h44); busy(1'b1); idle;
    w(8'hea, 8'h05); w(8'h18, 8'h99);
    r(8'h18); chk({7'h00, e}, 8'h01);
    w(8'hea, 8'h01); busy(1'b0);
    r(8'h18); chk(d, 8'h44);
    $display("test row done");
    w(8'he8, 8'h10); w(8'h00, 8'h5a); r(8'h00); chk(d, 8'h5a);
    chk({7'h00, nvmPowered}, 8'h00);
    w(8'he8, 8'h01); r(8'h05); chk(d, 8'ha5);
    r(8'he8); chk({7'h00, v}, 8'h00);
    w(8'hea, 8'h40); r(8'h05); chk({7'h00, e}, 8'h01);
    w(8'hea, 8'h00); @(negedge clk);
    chk({7'h00, nvmPowered}, 8'h01);
    stopExec = 1'b1; @(negedge clk); stopExec = 1'b0; @(negedge clk);
    chk({7'h00, nvmPowered}, 8'h00);
    wakeUp = 1'b1; @(negedge clk); wakeUp = 1'b0;
    rst_b = 1'b0; @(negedge clk); rst_b = 1'b1;
    r(8'h05); chk(d, 8'ha5);
    $display("test bank done");
    test_done;
  end
endmodule // banked_eeprom_controller_test

// ===== verification/cpu_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Core side: one strobe per access, changed at falling edges
module cpu_core_model (
  // Clock
  input wire clk,
  // Requests
  output reg [7:0] addr,
  output reg rdEn,
  output reg wrEn,
  output reg [7:0] wrData,
  // Answers
  input wire [7:0] rdData,
  input wire rdValid,
  input wire accessError
);
  initial begin
    addr = 8'h00;
    rdEn = 1'b0;
    wrEn = 1'b0;
    wrData = 8'h00;
  end
  // Callers pass whole bytes, one bank bit, control bits 5 and 4 clear.
  task wr(input [7:0] a, input [7:0] dt);
    begin
      @(negedge clk);
      addr = a;
      wrData = dt;
      wrEn = 1'b1;
      @(negedge clk);
      wrEn = 1'b0;
      addr = ~a;
      wrData = ~dt;
    end
  endtask
  // Answers stand one cycle, so every falling edge is looked at.
  task rd(input [7:0] a, output [7:0] d, output v, output e);
    integer i;
    begin
      v = 1'b0;
      e = 1'b0;
      d = 8'h00;
      @(negedge clk);
      addr = a;
      rdEn = 1'b1;
      @(negedge clk);
      rdEn = 1'b0;
      addr = ~a;
      // The error pulse stands in the cycle right after the request.
      if (accessError === 1'b1)
        e = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge clk);
        if (rdValid === 1'b1) begin
          v = 1'b1;
          d = rdData;
        end
        if (accessError === 1'b1)
          e = 1'b1;
      end
    end
  endtask
endmodule // cpu_core_model
